// ==== hw/rsc_pkg.sv ====
// Purpose: constants and types for the reset and strap capture block
// Assumes: 100 MHz system clock
// Notes:   strap defaults mirror the internal pull of each pin
`default_nettype none
package rsc_pkg;

    // ************************************************
    // timing
    // ************************************************
    localparam int unsigned RSC_SYS_CLK_HZ      = 100_000_000;
    localparam int unsigned RSC_PHY_CLOCK_HZ    = 25_000_000;
    // half period of the phy clock in system cycles
    localparam int unsigned RSC_PHY_CLOCK_HALF  = RSC_SYS_CLK_HZ / (2 * RSC_PHY_CLOCK_HZ);
    localparam int unsigned RSC_STRETCH_CYCLES  = 1024;
    localparam int unsigned RSC_ZC_FILTER_CYCLES = 16;
    // driver side hold time, kept for reference only; the bench does not use it
    localparam int unsigned RSC_RST_HOLD_MS     = 100;

    // ************************************************
    // strap pull defaults (level of an open pin)
    // ************************************************
    localparam logic [1:0] RSC_PULL_ETHER_SEL  = 2'h3;
    localparam logic       RSC_PULL_AUTONEG    = 1'h1;
    localparam logic       RSC_PULL_ISOLATE    = 1'h0;
    localparam logic [1:0] RSC_PULL_SPEED      = 2'h1;
    localparam logic       RSC_PULL_ADDR3      = 1'h1;
    localparam logic       RSC_PULL_ADDR4      = 1'h0;
    localparam logic       RSC_PULL_MEM_CFG    = 1'h1;
    localparam logic       RSC_PULL_HOST_ROLE  = 1'h1;
    localparam logic       RSC_PULL_BOOT_SRC   = 1'h1;
    localparam logic       RSC_PULL_DUPLEX     = 1'h1;

    // ************************************************
    // field encodings
    // ************************************************
    localparam logic [1:0] RSC_SPEED_10M       = 2'h0;
    localparam logic [1:0] RSC_SPEED_100M      = 2'h1;
    localparam int unsigned RSC_ADDR_W         = 5;
    localparam int unsigned RSC_ADDR_LO        = 3;

    // raw strap levels as sampled
    typedef struct packed {
        logic [1:0] ether_if_select;
        logic       autoneg_strap;
        logic       isolate_strap;
        logic [1:0] speed_strap;
        logic       mgmt_addr_bit3_strap;
        logic       mgmt_addr_bit4_strap;
        logic       mem_cfg_strap;
        logic       host_role_strap;
        logic       boot_source_strap;
        logic       duplex_strap;
    } rsc_straps_t;

    localparam rsc_straps_t RSC_STRAP_DEFAULT = '{
        ether_if_select:      RSC_PULL_ETHER_SEL,
        autoneg_strap:        RSC_PULL_AUTONEG,
        isolate_strap:        RSC_PULL_ISOLATE,
        speed_strap:          RSC_PULL_SPEED,
        mgmt_addr_bit3_strap: RSC_PULL_ADDR3,
        mgmt_addr_bit4_strap: RSC_PULL_ADDR4,
        mem_cfg_strap:        RSC_PULL_MEM_CFG,
        host_role_strap:      RSC_PULL_HOST_ROLE,
        boot_source_strap:    RSC_PULL_BOOT_SRC,
        duplex_strap:         RSC_PULL_DUPLEX
    };

    // decoded configuration
    typedef struct packed {
        logic [1:0]            ether_if_select;
        logic                  mac_mode;
        logic                  autoneg_en;
        logic                  isolate;
        logic                  speed_100;
        logic                  speed_reserved;
        logic [RSC_ADDR_W-1:0] mgmt_addr;
        logic                  full_duplex;
        logic                  mem_cfg_flash;
        logic                  boot_flash;
        logic                  boot_unsupported;
    } rsc_cfg_t;

    localparam rsc_cfg_t RSC_CFG_RESET = '0;

endpackage : rsc_pkg
`default_nettype wire

// ==== hw/rsc_reset_strap_capture.sv ====
// Purpose: reset stretch, phy clock, strap capture and zero-cross filter
// Assumes: all inputs synchronous to sys_clk; strap pads have pulls outside
// Notes:   straps are caught once per module reset release
//
// How it works
// - phy reset is stretched copy of module reset
// - 25 MHz phy clock only in MAC mode
// - low module reset holds all logic reset except the captured cfg, which keeps its value
// - zero-cross input times channel adaptation
// - straps set mode, never re-evaluated later
// - open strap pins read their pull default
// - PHY mode autoneg strap high enables
// - PHY mode isolate strap high isolates
// - address straps give management address bits 4:3
// - clock pin doubles as duplex strap
// - memory-config strap high reads DDR from flash
// - boot-source strap high boots from flash
// - only both boot straps high supported
// - speed strap 00 10M, 01 100M
`timescale 1ns/100ps
`default_nettype none
module rsc_reset_strap_capture
    import rsc_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = RSC_STRETCH_CYCLES,
    parameter int unsigned ZC_FILTER      = RSC_ZC_FILTER_CYCLES
)
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        sys_rst,
    // module reset pin
    input  wire logic        module_reset_n,
    // strap pads: level and a flag that the pad is left open
    input  wire rsc_straps_t strap_level,
    input  wire rsc_straps_t strap_open,
    // zero cross
    input  wire logic        zero_cross_in,
    // external phy
    output var  logic        ext_phy_reset_n,
    output var  logic        ext_phy_clock_out,
    output var  logic        ext_phy_clock_oe,
    // core reset and configuration
    output var  logic        core_reset,
    output var  logic        cfg_valid,
    output var  rsc_cfg_t    cfg,
    // zero cross events for channel adaptation
    output var  logic        zc_level,
    output var  logic        zc_edge
);

    // ************************************************
    // widths and end counts
    // ************************************************
    // counters are sized to reach their end value exactly
    localparam int unsigned SW = $clog2(STRETCH_CYCLES + 1);
    localparam int unsigned HW = $clog2(RSC_PHY_CLOCK_HALF + 1);
    localparam int unsigned ZW = $clog2(ZC_FILTER + 1);
    localparam logic [SW-1:0] STRETCH_LAST = SW'(STRETCH_CYCLES);
    localparam logic [HW-1:0] HALF_LAST    = HW'(RSC_PHY_CLOCK_HALF - 1);
    localparam logic [ZW-1:0] ZC_LAST      = ZW'(ZC_FILTER);

    // ************************************************
    // strap resolve and decode
    // ************************************************
    // open pins read as their pull, driven pins as driven
    function automatic rsc_straps_t resolve(input rsc_straps_t lvl, input rsc_straps_t opn);
        resolve = (lvl & ~opn) | (RSC_STRAP_DEFAULT & opn);
    endfunction

    function automatic rsc_cfg_t decode(input rsc_straps_t s);
        rsc_cfg_t c;
        c                  = RSC_CFG_RESET;
        c.ether_if_select  = s.ether_if_select;
        c.mac_mode         = s.host_role_strap;
        // phy-mode options only meaningful while not MAC
        c.autoneg_en       = ~s.host_role_strap & s.autoneg_strap;
        c.isolate          = ~s.host_role_strap & s.isolate_strap;
        c.speed_100        = ~s.host_role_strap & (s.speed_strap == RSC_SPEED_100M);
        c.speed_reserved   = ~s.host_role_strap & s.speed_strap[1];
        // address kept in mac mode too; only a phy-mode host reads it
        c.mgmt_addr        = {s.mgmt_addr_bit4_strap, s.mgmt_addr_bit3_strap,
                              3'h0};
        c.full_duplex      = ~s.host_role_strap & s.duplex_strap;
        c.mem_cfg_flash    = s.mem_cfg_strap;
        c.boot_flash       = s.boot_source_strap;
        c.boot_unsupported = ~(s.boot_source_strap & s.mem_cfg_strap);
        return c;
    endfunction

    // ************************************************
    // reset input tracking and stretch
    // ************************************************
    logic          in_rst;
    logic          mod_rst_d_r,  mod_rst_d_nxt;
    logic [SW-1:0] stretch_r,    stretch_nxt;
    logic          ext_phy_reset_n_n_r,  ext_phy_reset_n_n_nxt;
    logic          core_rst_r,   core_rst_nxt;

    assign in_rst = sys_rst | ~module_reset_n;

    // the count restarts on every reassertion, so a bouncing reset pin
    // lengthens the phy reset rather than cutting it short

    always_comb
    begin
        mod_rst_d_nxt = ~module_reset_n;
        stretch_nxt   = stretch_r;
        ext_phy_reset_n_n_nxt = ext_phy_reset_n_n_r;
        core_rst_nxt  = in_rst;
        if (in_rst)
        begin
            stretch_nxt   = '0;
            ext_phy_reset_n_n_nxt = 1'b0;
        end
        else if (stretch_r != STRETCH_LAST)
        begin
            stretch_nxt   = stretch_r + 1'b1;
            ext_phy_reset_n_n_nxt = 1'b0;
        end
        else
        begin
            ext_phy_reset_n_n_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            mod_rst_d_r <= 1'b1;
            stretch_r   <= '0;
            ext_phy_reset_n_n_r <= 1'b0;
            core_rst_r  <= 1'b1;
        end
        else
        begin
            mod_rst_d_r <= mod_rst_d_nxt;
            stretch_r   <= stretch_nxt;
            ext_phy_reset_n_n_r <= ext_phy_reset_n_n_nxt;
            core_rst_r  <= core_rst_nxt;
        end
    end

    // ************************************************
    // strap capture
    // ************************************************
    // one sample at the release edge; the pins turn into led drivers after
    // boot, so any later sampling would read firmware traffic
    logic     release_edge;
    rsc_cfg_t cfg_r,   cfg_nxt;
    logic     valid_r, valid_nxt;

    assign release_edge = mod_rst_d_r & module_reset_n;

    // a reassertion drops cfg_valid but keeps cfg; users must gate on
    // cfg_valid before trusting any field

    always_comb
    begin
        cfg_nxt   = cfg_r;
        valid_nxt = valid_r;
        if (~module_reset_n)
        begin
            valid_nxt = 1'b0;
        end
        else if (release_edge)
        begin
            cfg_nxt   = decode(resolve(strap_level, strap_open));
            valid_nxt = 1'b1;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            cfg_r   <= RSC_CFG_RESET;
            valid_r <= 1'b0;
        end
        else
        begin
            cfg_r   <= cfg_nxt;
            valid_r <= valid_nxt;
        end
    end

    // ************************************************
    // phy clock
    // ************************************************
    logic          clk_r,   clk_nxt;
    logic          oe_r,    oe_nxt;
    logic [HW-1:0] half_r,  half_nxt;

    // pin stays undriven in PHY mode so it can serve as duplex strap;
    // the clock starts one cycle after capture while the phy reset is
    // still low, so the phy sees a settled clock before it wakes
    always_comb
    begin
        clk_nxt  = clk_r;
        half_nxt = half_r;
        oe_nxt   = valid_r & cfg_r.mac_mode;
        if (in_rst | ~oe_nxt)
        begin
            clk_nxt  = 1'b0;
            half_nxt = '0;
        end
        else if (half_r == HALF_LAST)
        begin
            clk_nxt  = ~clk_r;
            half_nxt = '0;
        end
        else
        begin
            half_nxt = half_r + 1'b1;
        end
        if (in_rst)
        begin
            oe_nxt = 1'b0;
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            clk_r  <= 1'b0;
            oe_r   <= 1'b0;
            half_r <= '0;
        end
        else
        begin
            clk_r  <= clk_nxt;
            oe_r   <= oe_nxt;
            half_r <= half_nxt;
        end
    end

    // ************************************************
    // zero cross filter
    // ************************************************
    // a level must hold ZC_FILTER cycles; opto edges ring on a noisy line.
    // on DC or dry wire the pin sits high and no edge is ever reported, so
    // adaptation then runs without line timing
    logic          zc_lvl_r,  zc_lvl_nxt;
    logic          zc_edge_r, zc_edge_nxt;
    logic [ZW-1:0] zc_cnt_r,  zc_cnt_nxt;

    always_comb
    begin
        zc_lvl_nxt  = zc_lvl_r;
        zc_edge_nxt = 1'b0;
        zc_cnt_nxt  = '0;
        if (in_rst)
        begin
            zc_lvl_nxt = 1'b1;
        end
        else if (zero_cross_in != zc_lvl_r)
        begin
            zc_cnt_nxt = zc_cnt_r + 1'b1;
            if (zc_cnt_r == ZC_LAST - 1'b1)
            begin
                zc_lvl_nxt  = zero_cross_in;
                zc_edge_nxt = zero_cross_in;
                zc_cnt_nxt  = '0;
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            zc_lvl_r  <= 1'b1;
            zc_edge_r <= 1'b0;
            zc_cnt_r  <= '0;
        end
        else
        begin
            zc_lvl_r  <= zc_lvl_nxt;
            zc_edge_r <= zc_edge_nxt;
            zc_cnt_r  <= zc_cnt_nxt;
        end
    end

    // ************************************************
    // outputs
    // ************************************************
    // every output is a flop; no logic between register and pin
    assign ext_phy_reset_n   = ext_phy_reset_n_n_r;
    assign ext_phy_clock_out = clk_r;
    assign ext_phy_clock_oe  = oe_r;
    assign core_reset        = core_rst_r;
    assign cfg_valid         = valid_r;
    assign cfg               = cfg_r;
    assign zc_level          = zc_lvl_r;
    assign zc_edge           = zc_edge_r;

endmodule // rsc_reset_strap_capture
`default_nettype wire

// ==== tb/rsc_asserts.sv ====
// Purpose: port-level checks of the reset and strap capture block
// Assumes: bound into the design top, one clock domain
// Notes:   cnt_r counts edges seen with module reset high
`timescale 1ns/100ps
`default_nettype none
module rsc_asserts
    import rsc_pkg::*;
#(
    parameter int unsigned STRETCH_CYCLES = RSC_STRETCH_CYCLES
)
(
    // clock and reset
    input wire logic     sys_clk,
    input wire logic     sys_rst,
    // pins
    input wire logic     module_reset_n,
    input wire logic     zero_cross_in,
    input wire logic     ext_phy_reset_n,
    input wire logic     ext_phy_clock_out,
    input wire logic     ext_phy_clock_oe,
    // core side
    input wire logic     core_reset,
    input wire logic     cfg_valid,
    input wire rsc_cfg_t cfg,
    input wire logic     zc_level
);
    // first sample that sees the stretched reset high
    localparam int unsigned REL = STRETCH_CYCLES + 1;
    int unsigned cnt_r;
    int unsigned cnt_nxt;
    // saturates just past the release point so it never wraps
    always_comb
    begin
        cnt_nxt = (sys_rst || !module_reset_n) ? 0 : ((cnt_r <= REL) ? cnt_r + 1 : cnt_r);
    end
    always_ff @(posedge sys_clk)
    begin
        cnt_r <= cnt_nxt;
    end
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (sys_rst);
    AST_PHYRST_LOW: assert property (!module_reset_n |=> !ext_phy_reset_n)
        else $error("phy reset high during module reset");
    AST_STRETCH_LOW: assert property (cnt_r < REL |-> !ext_phy_reset_n)
        else $error("phy reset released early");
    AST_STRETCH_END: assert property (cnt_r == REL |-> $rose(ext_phy_reset_n))
        else $error("phy reset not released at stretch end");
    AST_CORE_RESET: assert property (!module_reset_n |=> core_reset && !cfg_valid)
        else $error("logic not held in reset");
    AST_CAPTURE: assert property (module_reset_n && !$past(module_reset_n) |=> cfg_valid)
        else $error("straps not captured at release");
    AST_CFG_HELD: assert property (cfg_valid && $past(cfg_valid) |-> $stable(cfg))
        else $error("configuration changed after capture");
    AST_NO_CLK_PHY: assert property (ext_phy_clock_oe |-> cfg_valid && cfg.mac_mode)
        else $error("phy clock driven outside mac mode");
    AST_CLK_IDLE: assert property (!ext_phy_clock_oe |-> !ext_phy_clock_out)
        else $error("clock pin active while released");
    AST_CLK_RATE: assert property (@(posedge sys_clk) disable iff (sys_rst || core_reset)
        $rose(ext_phy_clock_out) |=> ext_phy_clock_out ##1 !ext_phy_clock_out [*2]
        ##1 ext_phy_clock_out)
        else $error("phy clock not two high two low");
    AST_ADDR_LOW: assert property (cfg_valid |-> cfg.mgmt_addr[2:0] == 3'h0)
        else $error("management address low bits set");
    AST_BOOT_FLAG: assert property (cfg_valid |->
        cfg.boot_unsupported == !(cfg.boot_flash && cfg.mem_cfg_flash))
        else $error("boot combination flag wrong");
    AST_ZC_FILTER: assert property (!core_reset && !$past(core_reset) && $changed(zc_level)
        |-> zc_level == $past(zero_cross_in))
        else $error("zero-cross level changed without input");
endmodule // rsc_asserts
`default_nettype wire

// ==== tb/rsc_pad_model.sv ====
// Purpose: reset driver, strap pads and zero-cross source
// Assumes: pads change on the falling edge of sys_clk
// Notes:   an open pad toggles so only the pull can give its level
`timescale 1ns/100ps
`default_nettype none
module rsc_pad_model
    import rsc_pkg::*;
#(
    parameter int unsigned HOLD_CYCLES = 20
)
(
    // clock
    input  wire logic       sys_clk,
    // pads toward the block
    output var logic        module_reset_n,
    output var rsc_straps_t strap_level,
    output var rsc_straps_t strap_open,
    output var logic        zero_cross_in
);
    rsc_straps_t lv_r;
    logic        tgl_r = 1'b0;
    assign strap_level = rsc_straps_t'(lv_r ^ (strap_open & {$bits(rsc_straps_t){tgl_r}}));
    initial
    begin
        module_reset_n = 1'b0;
        lv_r           = '0;
        strap_open     = '1;
        zero_cross_in  = 1'b1;
    end
    always @(negedge sys_clk)
    begin
        tgl_r <= !tgl_r;
    end
    // levels come through resistors, the block may later drive the pins
    task automatic set_straps(input rsc_straps_t lv, input rsc_straps_t op);
        @(negedge sys_clk);
        lv_r       = lv;
        strap_open = op;
    endtask
    task automatic pulse_reset(input rsc_straps_t lv, input rsc_straps_t op);
        @(negedge sys_clk);
        module_reset_n = 1'b0;
        set_straps(lv, op);
        repeat (HOLD_CYCLES) @(negedge sys_clk);
        module_reset_n = 1'b1;
    endtask
    task automatic set_zc(input logic v, input int unsigned n);
        @(negedge sys_clk);
        zero_cross_in = v;
        repeat (n) @(negedge sys_clk);
    endtask
endmodule // rsc_pad_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Purpose: self-checking bench for the reset and strap capture block
// Assumes: short stretch and filter counts keep the run brief
// Notes:   the decode is rebuilt here from the pull defaults
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e, m) begin checks_done++; if ((g) !== (e)) begin err_count++; \
    $display("MISMATCH %0t %s", $time, m); end end
module tb_top
    import rsc_pkg::*;
;
    localparam int unsigned STRETCH = 8;
    logic        sys_clk;
    logic        sys_rst;
    logic        module_reset_n;
    logic        zero_cross_in;
    rsc_straps_t strap_level;
    rsc_straps_t strap_open;
    logic        ext_phy_reset_n;
    logic        ext_phy_clock_out;
    logic        ext_phy_clock_oe;
    logic        core_reset;
    logic        cfg_valid;
    rsc_cfg_t    cfg;
    logic        zc_level;
    logic        zc_edge;
    int          err_count;
    int          checks_done;
    rsc_reset_strap_capture #(.STRETCH_CYCLES(STRETCH), .ZC_FILTER(2)) dut (
        .sys_clk(sys_clk), .sys_rst(sys_rst), .module_reset_n(module_reset_n),
        .strap_level(strap_level), .strap_open(strap_open), .zero_cross_in(zero_cross_in),
        .ext_phy_reset_n(ext_phy_reset_n), .ext_phy_clock_out(ext_phy_clock_out),
        .ext_phy_clock_oe(ext_phy_clock_oe), .core_reset(core_reset), .cfg_valid(cfg_valid),
        .cfg(cfg), .zc_level(zc_level), .zc_edge(zc_edge));
    rsc_pad_model u_pad (.sys_clk(sys_clk), .module_reset_n(module_reset_n),
        .strap_level(strap_level), .strap_open(strap_open), .zero_cross_in(zero_cross_in));
    // ************************************************
    // expectations and checks
    // ************************************************
    function automatic rsc_cfg_t exp_cfg(input rsc_straps_t lv, input rsc_straps_t op);
        rsc_straps_t e;
        rsc_cfg_t    c;
        logic        p;
        e = rsc_straps_t'((lv & ~op) | (RSC_STRAP_DEFAULT & op));
        p = !e.host_role_strap;
        c.ether_if_select  = e.ether_if_select;
        c.mac_mode         = e.host_role_strap;
        c.autoneg_en       = p & e.autoneg_strap;
        c.isolate          = p & e.isolate_strap;
        c.speed_100        = p & (e.speed_strap == RSC_SPEED_100M);
        c.speed_reserved   = p & e.speed_strap[1];
        c.mgmt_addr        = {e.mgmt_addr_bit4_strap, e.mgmt_addr_bit3_strap, 3'h0};
        c.full_duplex      = p & e.duplex_strap;
        c.mem_cfg_flash    = e.mem_cfg_strap;
        c.boot_flash       = e.boot_source_strap;
        c.boot_unsupported = !(e.mem_cfg_strap & e.boot_source_strap);
        return c;
    endfunction
    task automatic test_done();
        if (err_count == 0 && checks_done > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    task automatic run_case(input rsc_straps_t lv, input rsc_straps_t op);
        rsc_cfg_t    ec;
        int unsigned k;
        int unsigned hi;
        ec = exp_cfg(lv, op);
        u_pad.pulse_reset(lv, op);
        @(posedge sys_clk);
        #1;
        `CHK(cfg_valid, 1'b1, "straps not captured")
        `CHK(cfg, ec, "decoded configuration")
        k = 0;
        while (ext_phy_reset_n !== 1'b1 && k < 4 * STRETCH)
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        `CHK(k, STRETCH, "phy reset stretch")
        hi = 0;
        repeat (16)
        begin
            @(posedge sys_clk);
            #1;
            hi += (ext_phy_clock_out === 1'b1);
        end
        `CHK(hi, ec.mac_mode ? 8 : 0, "phy clock presence")
        `CHK(ext_phy_clock_oe, ec.mac_mode, "clock pin drive")
        u_pad.set_straps(rsc_straps_t'($urandom), rsc_straps_t'($urandom));
        repeat (4) @(posedge sys_clk);
        #1;
        `CHK(cfg, ec, "straps evaluated again")
    endtask
    initial
    begin
        sys_clk = 1'b0;
        forever #5 sys_clk = !sys_clk;
    end
    // the whole sequence needs about 6 us
    initial
    begin
        #100000;
        err_count++;
        test_done();
    end
    initial
    begin
        rsc_straps_t lv;
        rsc_straps_t op;
        int unsigned k;
        sys_rst = 1'b1;
        err_count = 0;
        checks_done = 0;
        void'($urandom(54781));
        repeat (5) @(posedge sys_clk);
        @(negedge sys_clk);
        sys_rst = 1'b0;
        run_case('0, '1);
        op = '1;
        op.host_role_strap = 1'b0;
        run_case('0, op);
        `CHK(cfg.mgmt_addr, 5'h08, "default address")
        for (int i = 0; i < 4; i++)
        begin
            lv = rsc_straps_t'($urandom);
            lv.host_role_strap = 1'b0;
            lv.speed_strap = 2'(i);
            {lv.boot_source_strap, lv.mem_cfg_strap} = 2'(i);
            run_case(lv, '0);
        end
        for (int i = 0; i < 4; i++)
        begin
            u_pad.pulse_reset(rsc_straps_t'($urandom), rsc_straps_t'($urandom));
            repeat (3) @(posedge sys_clk);
            lv = rsc_straps_t'($urandom);
            op = rsc_straps_t'($urandom);
            run_case(lv, op);
        end
        u_pad.set_straps(lv, op);
        sys_rst = 1'b1;
        repeat (2) @(negedge sys_clk);
        sys_rst = 1'b0;
        @(posedge sys_clk);
        #1;
        `CHK(cfg, exp_cfg(lv, op), "capture after system reset")
        u_pad.set_zc(1'b0, 0);
        @(posedge sys_clk);
        #1;
        `CHK(zc_level, 1'b1, "zero-cross glitch passed")
        u_pad.set_zc(1'b1, 4);
        `CHK(zc_level, 1'b1, "zero-cross level lost")
        u_pad.set_zc(1'b0, 8);
        `CHK(zc_level, 1'b0, "zero-cross low missed")
        u_pad.set_zc(1'b1, 0);
        k = 0;
        while (zc_edge !== 1'b1 && k < 10)
        begin
            @(posedge sys_clk);
            #1;
            k++;
        end
        `CHK(zc_edge, 1'b1, "zero-cross edge missing")
        test_done();
    end
endmodule // tb_top
bind rsc_reset_strap_capture rsc_asserts #(.STRETCH_CYCLES(STRETCH_CYCLES)) u_chk (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .module_reset_n(module_reset_n),
    .zero_cross_in(zero_cross_in), .ext_phy_reset_n(ext_phy_reset_n),
    .ext_phy_clock_out(ext_phy_clock_out), .ext_phy_clock_oe(ext_phy_clock_oe),
    .core_reset(core_reset), .cfg_valid(cfg_valid), .cfg(cfg), .zc_level(zc_level));
`default_nettype wire
